// file: rtl/ldc_pkg.sv
// Constants and decode tables for the lane drive configuration register bank.
// Functional notes
// - Clock emphasis bits 6:4, used only in fixed-rate mode.
// - Emphasis codes decode to dB; code 3 reserved.
// - Lane 1 emphasis bits 6:4, reset zero.
// - Clock boost bits 3:0, used only in fixed-rate mode.
// - Lane 0 boost rises monotonically from 0 to F.
// - Lane 1 boost: 0 minimum, F maximum.
// - Lane 0 swing decoded by limited or linear mode.
// - Lane 1 swing resets to 3: 1000/1200 mV.
// - Clock swing code 3 gives 800/1200 mV.
// - Boost registers reset 00h, upper nibble reserved.
// - Global select: 0 limited, 1 linear swing.
package ldc_pkg;
   localparam int           NUM_LANES         = 3;
   localparam int           LANE_CLOCK        = 0;
   localparam int           LANE_DATA0        = 1;
   localparam int           LANE_DATA1        = 2;
   localparam logic [7:0]   OFS_CLOCK_DRIVE   = 8'h12;
   localparam logic [7:0]   OFS_CLOCK_EQ      = 8'h13;
   localparam logic [7:0]   OFS_LANE0_DRIVE   = 8'h14;
   localparam logic [7:0]   OFS_LANE0_EQ      = 8'h15;
   localparam logic [7:0]   OFS_LANE1_DRIVE   = 8'h16;
   localparam logic [7:0]   OFS_LANE1_EQ      = 8'h17;
   localparam int           EMPH_MSB          = 6;
   localparam int           EMPH_LSB          = 4;
   localparam int           SWING_MSB         = 2;
   localparam int           SWING_LSB         = 0;
   localparam int           BOOST_MSB         = 3;
   localparam int           BOOST_LSB         = 0;
   localparam logic [2:0]   RST_EMPHASIS      = 3'h0;
   localparam logic [2:0]   RST_SWING         = 3'h3;
   localparam logic [3:0]   RST_BOOST         = 4'h0;
   localparam logic [2:0]   EMPH_RESERVED     = 3'h3;
   localparam logic [2:0]   SWING_LIN_MAXCODE = 3'h3;
   localparam logic [2:0]   SWING_NOMINAL     = 3'h3;
   localparam logic [11:0]  MV_CLOCK_LIMITED3 = 12'h320;
   // Emphasis in tenths of a dB, signed, indexed by code.
   localparam logic signed [7:0] EMPH_DB [8] =
      '{8'sh00, 8'sh23, 8'sh3c, 8'sh00, -8'sh0f, -8'sh19, -8'sh23, -8'sh30};
   // Limited-mode swing around a 1000 mV nominal: -15% to +20% in 5% steps.
   localparam logic [11:0] MV_LIMITED [8] =
      '{12'h352, 12'h384, 12'h3b6, 12'h3e8, 12'h41a, 12'h44c, 12'h47e, 12'h4b0};
   // Linear-mode swing for codes 0 to 3; higher codes are reserved.
   localparam logic [11:0] MV_LINEAR [4] = '{12'h320, 12'h384, 12'h3e8, 12'h4b0};
endpackage : ldc_pkg

// file: rtl/ldc_lane_drive_config_regs.sv
// Register bank and analog-setting decode for the clock lane and data lanes 0 and 1.
`timescale 1ns/1ps
module ldc_lane_drive_config_regs (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic [7:0]          regAddr,
   input  wire logic                regWrEn,
   input  wire logic [7:0]          regWrData,
   input  wire logic                regRdEn,
   output logic      [7:0]          regRdData,
   output logic                     regRdValid,
   input  wire logic                linearRedriverSelect,
   input  wire logic                fixedRateLinkMode,
   output logic signed [2:0][7:0]   laneEmphasisTenthDb,
   output logic      [2:0]          laneEmphasisReserved,
   output logic      [2:0][11:0]    laneSwingMv,
   output logic      [2:0]          laneSwingReserved,
   output logic      [2:0][3:0]     laneBoost
);

   // Stored codes, one entry per lane, unpacked so that each lane's process owns its own entry.
   logic [2:0] emphasis_q [ldc_pkg::NUM_LANES];
   logic [2:0] swing_q    [ldc_pkg::NUM_LANES];
   logic [3:0] boost_q    [ldc_pkg::NUM_LANES];

   genvar gl;
   generate
      for (gl = 0; gl < ldc_pkg::NUM_LANES; gl++) begin : g_lane
         localparam logic [7:0] DRIVE_OFS = ldc_pkg::OFS_CLOCK_DRIVE + 8'(2 * gl);
         localparam logic [7:0] EQ_OFS    = ldc_pkg::OFS_CLOCK_EQ + 8'(2 * gl);
         logic        honoured;
         logic [11:0] swingMv_d;
         logic        swingRsv_d;
         logic [7:0]  emphTenthDb_q;
         logic        emphRsv_q;
         logic [11:0] swingMv_q;
         logic        swingRsv_q;
         logic [3:0]  boostApplied_q;

         // Only the coded fields are stored, so reserved bits can never hold a one.
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               emphasis_q[gl] <= ldc_pkg::RST_EMPHASIS;
               swing_q[gl]    <= ldc_pkg::RST_SWING;
            end else if (regWrEn && regAddr == DRIVE_OFS) begin
               emphasis_q[gl] <= regWrData[ldc_pkg::EMPH_MSB:ldc_pkg::EMPH_LSB];
               swing_q[gl]    <= regWrData[ldc_pkg::SWING_MSB:ldc_pkg::SWING_LSB];
            end
         end

         // Boost register: upper nibble is not stored and resets to zero.
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               boost_q[gl] <= ldc_pkg::RST_BOOST;
            end else if (regWrEn && regAddr == EQ_OFS) begin
               boost_q[gl] <= regWrData[ldc_pkg::BOOST_MSB:ldc_pkg::BOOST_LSB];
            end
         end

         // The clock lane ignores emphasis and boost outside the fixed-rate generation.
         assign honoured = (gl != ldc_pkg::LANE_CLOCK) || fixedRateLinkMode;

         // Swing depends on the global redriver select; the clock lane differs at code 3 in limited mode.
         always_comb begin
            swingRsv_d = 1'b0;
            if (linearRedriverSelect) begin
               if (swing_q[gl] > ldc_pkg::SWING_LIN_MAXCODE) begin
                  swingMv_d  = 12'h000;
                  swingRsv_d = 1'b1;
               end else begin
                  swingMv_d = ldc_pkg::MV_LINEAR[swing_q[gl][1:0]];
               end
            end else if (gl == ldc_pkg::LANE_CLOCK && swing_q[gl] == ldc_pkg::SWING_NOMINAL) begin
               swingMv_d = ldc_pkg::MV_CLOCK_LIMITED3;
            end else begin
               swingMv_d = ldc_pkg::MV_LIMITED[swing_q[gl]];
            end
         end

         // Decoded settings are registered so the analog side sees glitch-free levels.
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               emphTenthDb_q  <= 8'h00;
               emphRsv_q      <= 1'b0;
               swingMv_q      <= 12'h000;
               swingRsv_q     <= 1'b0;
               boostApplied_q <= 4'h0;
            end else begin
               emphTenthDb_q  <= honoured ? ldc_pkg::EMPH_DB[emphasis_q[gl]] : 8'h00;
               emphRsv_q      <= honoured && emphasis_q[gl] == ldc_pkg::EMPH_RESERVED;
               swingMv_q      <= swingMv_d;
               swingRsv_q     <= swingRsv_d;
               boostApplied_q <= honoured ? boost_q[gl] : 4'h0;
            end
         end

         // Each lane drives only its own slice of the packed outputs, straight from the flops.
         assign laneEmphasisTenthDb[gl]  = emphTenthDb_q;
         assign laneEmphasisReserved[gl] = emphRsv_q;
         assign laneSwingMv[gl]          = swingMv_q;
         assign laneSwingReserved[gl]    = swingRsv_q;
         assign laneBoost[gl]            = boostApplied_q;
      end
   endgenerate

   // Read port: unmapped offsets return zero, reserved bits always read zero.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            case (regAddr)
               ldc_pkg::OFS_CLOCK_DRIVE: regRdData <= {1'b0, emphasis_q[0], 1'b0, swing_q[0]};
               ldc_pkg::OFS_CLOCK_EQ:    regRdData <= {4'h0, boost_q[0]};
               ldc_pkg::OFS_LANE0_DRIVE: regRdData <= {1'b0, emphasis_q[1], 1'b0, swing_q[1]};
               ldc_pkg::OFS_LANE0_EQ:    regRdData <= {4'h0, boost_q[1]};
               ldc_pkg::OFS_LANE1_DRIVE: regRdData <= {1'b0, emphasis_q[2], 1'b0, swing_q[2]};
               ldc_pkg::OFS_LANE1_EQ:    regRdData <= {4'h0, boost_q[2]};
               default:                  regRdData <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Outside the fixed-rate generation the clock lane shows no emphasis one edge later.
   a_clk_emph_gate: assert property (
      !fixedRateLinkMode |=> laneEmphasisTenthDb[0] == 8'sh00 || $past(fixedRateLinkMode))
      else $error("clock emphasis applied outside fixed-rate mode");

   // An ignored clock emphasis code must not raise the reserved-code flag either.
   a_clk_rsv_gate: assert property (
      !fixedRateLinkMode |=> !laneEmphasisReserved[0])
      else $error("clock emphasis reserved flag raised while ignored");

   // The most negative emphasis code is checked against its tenths-of-a-dB value.
   a_emph_decode: assert property (
      emphasis_q[1] == 3'h7 |=> laneEmphasisTenthDb[1] == -8'sh30)
      else $error("emphasis code 7 not decoded to -4.8 dB");

   // A reserved emphasis code is flagged and applies no emphasis at all.
   a_emph_rsv_flag: assert property (
      emphasis_q[1] == ldc_pkg::EMPH_RESERVED
      |=> laneEmphasisReserved[1] && laneEmphasisTenthDb[1] == 8'h00)
      else $error("reserved emphasis code not flagged");

   // A write lands in the store one edge later and in the decoded output one edge after that.
   a_lane1_emph_wr: assert property (
      regWrEn && regAddr == ldc_pkg::OFS_LANE1_DRIVE
      |=> emphasis_q[2] == $past(regWrData[ldc_pkg::EMPH_MSB:ldc_pkg::EMPH_LSB])
      ##1 laneEmphasisTenthDb[2]
          == ldc_pkg::EMPH_DB[$past(regWrData[ldc_pkg::EMPH_MSB:ldc_pkg::EMPH_LSB], 2)]
      || $changed(emphasis_q[2]))
      else $error("lane 1 emphasis write not applied");

   // Clock boost is forced to minimum while the link is not in the fixed-rate generation.
   a_clk_boost_gate: assert property (
      !fixedRateLinkMode |=> laneBoost[0] == 4'h0)
      else $error("clock boost applied outside fixed-rate mode");

   // Lane 0 boost is the stored code itself, so a higher code never gives less boost.
   a_lane0_boost: assert property (
      ##1 laneBoost[1] == $past(boost_q[1]))
      else $error("lane 0 boost does not follow its code");

   // Writing the top code to lane 1 must reach maximum boost two edges later.
   a_lane1_boost: assert property (
      regWrEn && regAddr == ldc_pkg::OFS_LANE1_EQ && regWrData[3:0] == 4'hf
      |=> ##1 laneBoost[2] == 4'hf || $changed(boost_q[2]))
      else $error("lane 1 maximum boost not applied");

   // The lowest linear swing code gives 800 mV.
   a_lane0_linear: assert property (
      linearRedriverSelect && swing_q[1] == 3'h0 |=> laneSwingMv[1] == 12'h320)
      else $error("lane 0 linear code 0 not 800 mV");

   // Reserved linear swing codes drive no swing target at all.
   a_lin_rsv_zero: assert property (
      linearRedriverSelect && swing_q[1] > ldc_pkg::SWING_LIN_MAXCODE
      |=> laneSwingMv[1] == 12'h000)
      else $error("reserved linear swing code drives a level");

   // The data lane reset swing code is 1000 mV in limited mode.
   a_lane1_nominal: assert property (
      !linearRedriverSelect && swing_q[2] == 3'h3 |=> laneSwingMv[2] == 12'h3e8)
      else $error("lane 1 limited code 3 not 1000 mV");

   // The same code gives 1200 mV once the linear redriver is selected.
   a_lane1_linear: assert property (
      linearRedriverSelect && swing_q[2] == ldc_pkg::SWING_NOMINAL
      |=> laneSwingMv[2] == 12'h4b0)
      else $error("lane 1 linear code 3 not 1200 mV");

   // The clock lane departs from the data lanes at code 3 in limited mode only.
   a_clk_swing3: assert property (
      swing_q[0] == 3'h3 |=> laneSwingMv[0] == ($past(linearRedriverSelect) ? 12'h4b0 : 12'h320))
      else $error("clock swing code 3 wrong");

   // The reserved upper nibble of the clock boost register reads back as zero.
   a_eq_read_zero: assert property (
      regRdEn && regAddr == ldc_pkg::OFS_CLOCK_EQ |=> regRdValid && regRdData[7:4] == 4'h0)
      else $error("boost register upper nibble not zero");

   // The data lane boost registers keep a zero upper nibble as well.
   a_lane_eq_read: assert property (
      regRdEn && (regAddr == ldc_pkg::OFS_LANE0_EQ || regAddr == ldc_pkg::OFS_LANE1_EQ)
      |=> regRdValid && regRdData[7:4] == 4'h0)
      else $error("lane boost register upper nibble not zero");

   // Linear mode flags the swing codes it cannot serve.
   a_swing_select: assert property (
      linearRedriverSelect && swing_q[1] > 3'h3 |=> laneSwingReserved[1])
      else $error("linear reserved swing not flagged");

   // Limited mode serves every swing code, so no lane may flag one as reserved.
   a_limited_norsv: assert property (
      !linearRedriverSelect
      |=> !laneSwingReserved[0] && !laneSwingReserved[1] && !laneSwingReserved[2])
      else $error("limited mode flagged a reserved swing");

   // Bits 7 and 3 of the drive registers are reserved; in the boost registers bit 3 is data.
   a_rsvd_read: assert property (
      regRdEn && (regAddr == ldc_pkg::OFS_CLOCK_DRIVE || regAddr == ldc_pkg::OFS_LANE0_DRIVE
      || regAddr == ldc_pkg::OFS_LANE1_DRIVE) |=> regRdData[7] == 1'b0 && regRdData[3] == 1'b0)
      else $error("reserved bit read as one");

   // Main scenarios: gated clock lane, reserved codes and read-back traffic.
   c_fixed_clock_emph: cover property (fixedRateLinkMode && emphasis_q[0] == 3'h1 ##1 1'b1);
   c_linear_reserved:  cover property (linearRedriverSelect && swing_q[1] == 3'h7);
   c_read_after_write: cover property (regWrEn && regAddr == ldc_pkg::OFS_LANE0_EQ ##1
                                       regRdEn && regAddr == ldc_pkg::OFS_LANE0_EQ);
   c_emph_reserved:    cover property (emphasis_q[1] == ldc_pkg::EMPH_RESERVED ##1
                                       laneEmphasisReserved[1]);
   c_clock_gated:      cover property (!fixedRateLinkMode && boost_q[0] == 4'hf ##1
                                       laneBoost[0] == 4'h0);

endmodule : ldc_lane_drive_config_regs

// file: tb/ldc_lane_drive_config_regs_tb.sv
// Self-checking bench for the lane drive configuration register bank.
`timescale 1ns/1ps
module ldc_lane_drive_config_regs_tb;
   logic                clk_sys, rst_n, regWrEn, regRdEn, regRdValid;
   logic                linearRedriverSelect, fixedRateLinkMode;
   logic [7:0]          regAddr, regWrData, regRdData;
   logic [2:0][7:0]     laneEmphasisTenthDb;
   logic [2:0]          laneEmphasisReserved, laneSwingReserved;
   logic [2:0][11:0]    laneSwingMv;
   logic [2:0][3:0]     laneBoost;
   int                  mismatches, tests_run;
   // Expected decodes, kept apart from the design's own tables.
   logic [7:0]  emT [8] = '{8'h00, 8'h23, 8'h3c, 8'h00, 8'hf1, 8'he7, 8'hdd, 8'hd0};
   logic [11:0] liT [8] = '{12'h352, 12'h384, 12'h3b6, 12'h3e8, 12'h41a, 12'h44c,
                            12'h47e, 12'h4b0};
   logic [11:0] lnT [8] = '{12'h320, 12'h384, 12'h3e8, 12'h4b0, 12'h0, 12'h0, 12'h0, 12'h0};
   ldc_lane_drive_config_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .linearRedriverSelect(linearRedriverSelect),
      .fixedRateLinkMode(fixedRateLinkMode), .laneEmphasisTenthDb(laneEmphasisTenthDb),
      .laneEmphasisReserved(laneEmphasisReserved), .laneSwingMv(laneSwingMv),
      .laneSwingReserved(laneSwingReserved), .laneBoost(laneBoost));
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One write strobe; decoded outputs are looked at after settle's three more edges.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle
   // Read waits for the valid pulse under a bound, so a silent port cannot hang the run.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int n;
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      #1;
      for (n = 0; n < 4 && regRdValid !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (regRdValid !== 1'b1) begin
         mismatches++;
         $display("[FAIL] regRdValid expected 1 seen 0");
         give_verdict();
      end else begin
         chk("regRdData", {4'h0, regRdData}, {4'h0, e});
      end
   endtask : rd
   initial begin
      {rst_n, regWrEn, regRdEn, linearRedriverSelect, regAddr, regWrData} = '0;
      fixedRateLinkMode = 1'b1;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle();
      chk("clkSwing", laneSwingMv[0], 12'h320);
      chk("d1Swing", laneSwingMv[2], 12'h3e8);
      for (int a = 8'h12; a < 8'h18; a++) rd(a[7:0], a[0] ? 8'h00 : 8'h03);
      $display("Test reset done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h16, {1'b1, c[2:0], 1'b1, 3'h3});
         settle();
         chk("d1Emph", {4'h0, laneEmphasisTenthDb[2]}, {4'h0, emT[c]});
         chk("d1EmphRsv", {11'h0, laneEmphasisReserved[2]}, {11'h0, c == 3});
         rd(8'h16, {1'b0, c[2:0], 1'b0, 3'h3});
      end
      $display("Test emphasis done");
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys);
         linearRedriverSelect <= m[0];
         for (int c = 0; c < 8; c++) begin
            wr(8'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
            settle();
            chk("d0Swing", laneSwingMv[1], m ? lnT[c] : liT[c]);
            chk("d0SwRsv", {11'h0, laneSwingReserved[1]}, {11'h0, m == 1 && c > 3});
            chk("d0Emph", {4'h0, laneEmphasisTenthDb[1]}, {4'h0, emT[c]});
            chk("d0EmphRsv", {11'h0, laneEmphasisReserved[1]}, {11'h0, c == 3});
         end
      end
      $display("Test swing done");
      wr(8'h12, 8'h13);
      wr(8'h13, 8'hff);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys);
         fixedRateLinkMode <= m[0];
         settle();
         chk("clkEmph", {4'h0, laneEmphasisTenthDb[0]}, m ? 12'h023 : 12'h0);
         chk("clkBoost", {8'h0, laneBoost[0]}, m ? 12'h00f : 12'h0);
         chk("clkSwLin", laneSwingMv[0], 12'h4b0);
         rd(8'h13, 8'h0f);
      end
      $display("Test clock lane done");
      wr(8'h15, 8'ha5);
      wr(8'h17, 8'h5f);
      settle();
      chk("d0Boost", {8'h0, laneBoost[1]}, 12'h005);
      chk("d1Boost", {8'h0, laneBoost[2]}, 12'h00f);
      rd(8'h15, 8'h05);
      rd(8'h20, 8'h00);
      $display("Test boost done");
      // A reset in mid-run must bring lane 0 boost and the lane 1 drive fields back to their reset codes.
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle();
      chk("d0BoostRst", {8'h0, laneBoost[1]}, 12'h000);
      chk("d1EmphRst", {4'h0, laneEmphasisTenthDb[2]}, 12'h000);
      chk("d1SwingRst", laneSwingMv[2], 12'h4b0);
      rd(8'h16, 8'h03);
      $display("Test mid-run reset done");
      give_verdict();
   end
endmodule : ldc_lane_drive_config_regs_tb
